// [hdl/spfc_params.svh]
/*
 * Constants for the self-programming flash control block: register
 * field positions, reset values, table pointer bounds and cycle timing.
 * Assumes inclusion by the block's package and design modules.
 */
`ifndef SPFC_PARAMS_SVH
`define SPFC_PARAMS_SVH

// Control register fields
`define SPFC_BIT_MEM_SEL     7
`define SPFC_BIT_CFG_SEL     6
`define SPFC_BIT_ROW_ERASE   4
`define SPFC_BIT_WR_ERR      3
`define SPFC_BIT_WR_UNLOCK   2
`define SPFC_BIT_CYC_LAUNCH  1
`define SPFC_BIT_FETCH       0
`define SPFC_CTRL_WMASK      8'hd4
`define SPFC_CTRL_RESET      8'h00

// Table pointer and array geometry
`define SPFC_PTR_W           22
`define SPFC_HOLD_SEL_W      3
`define SPFC_HOLD_DEPTH      8
`define SPFC_ROW_LSB         6
`define SPFC_BLOCK_LSB       3
`define SPFC_PTR_STEP_W      21

// Programming timer, microseconds and derived cycles at 25 MHz
`define SPFC_CLK_MHZ         25
`define SPFC_PROG_TIME_US    2000
`define SPFC_PROG_CYCLES     (`SPFC_PROG_TIME_US * `SPFC_CLK_MHZ)
`define SPFC_UNLOCK_READ     8'h00
`define SPFC_NOP_WORD        16'h0000

`endif

// [hdl/spfc_pkg.sv]
/*
 * Types for the self-programming flash control block.
 * Assumes the params header is on the include path.
 */
`include "spfc_params.svh"

package spfc_pkg;

    // Table pointer update variant of a table operation
    typedef enum logic [1:0] {
        SPFC_PTR_HOLD    = 2'b00,
        SPFC_PTR_POSTINC = 2'b01,
        SPFC_PTR_POSTDEC = 2'b10,
        SPFC_PTR_PREINC  = 2'b11
    } spfc_ptr_mode_e;

    // Sequencer states
    typedef enum logic [1:0] {
        SPFC_IDLE  = 2'b00,
        SPFC_WRITE = 2'b01,
        SPFC_ERASE = 2'b10,
        SPFC_DREAD = 2'b11
    } spfc_state_e;

    // One table operation request from the core
    typedef struct packed {
        logic           rd;
        logic           wr;
        spfc_ptr_mode_e mode;
    } spfc_tbl_req_s;

    // Command to the memory array
    typedef struct packed {
        logic        prog;
        logic        erase;
        logic        cfg;
        logic [21:0] addr;
    } spfc_array_cmd_s;

endpackage

// [hdl/spfc_hold_regs.sv]
/*
 * Eight program holding registers written byte by byte from the table
 * data latch. Assumes one clock and an asynchronous active high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module spfc_hold_regs
    import spfc_pkg::*;
#(
    parameter int DEPTH = `SPFC_HOLD_DEPTH,
    parameter int SEL_W = `SPFC_HOLD_SEL_W
) (
    input  wire logic               clock_i,
    input  wire logic               reset_i,
    input  wire logic               wr_i,
    input  wire logic [SEL_W-1:0]   sel_i,
    input  wire logic [7:0]         data_i,
    output logic      [DEPTH*8-1:0] block_o
);

    // One byte register per entry
    for (genvar g = 0; g < DEPTH; g++) begin : g_byte
        logic [7:0] hold_byte;
        wire        hit = wr_i && (sel_i == SEL_W'(g));
        always_ff @(posedge clock_i or posedge reset_i) begin
            if (reset_i) begin
                hold_byte <= 8'hff;
            end else if (hit) begin
                hold_byte <= data_i;
            end
        end
        assign block_o[g*8 +: 8] = hold_byte;
    end

endmodule

`default_nettype wire

// [hdl/spfc_top.sv]
/*
 * Self-programming flash control: table data latch, table pointer,
 * holding registers, control register and self-timed write/erase
 * sequencer. Assumes the core issues table operations and control
 * register accesses as one-cycle strobes, and that the array answers
 * reads combinationally. Reset_i covers every device reset source.
 */
`timescale 1ns/1ps
`default_nettype none
`include "spfc_params.svh"

// Summary of operation
// - Read flash per byte, program eight-byte blocks, erase 64-byte rows
// - Whole-array erase requested by on-chip code is refused
// - Instruction fetch halts while a write or erase runs
// - Internal timer sets and ends each write and erase cycle
// - Words decoding to no valid instruction execute as no-operation
// - Wide program memory and byte RAM exchange single bytes via latch
// - Table write stores latch byte in holding register by pointer bits 2:0
// - Table transfers accept any byte address, no alignment needed
// - Unlock port stores nothing and reads as zero
// - With configuration select clear, memory select picks flash or data
// - Configuration select set steers accesses to configuration space
// - Row erase bit makes next launch erase row, cleared at completion
// - Cycle launch cannot be set while write unlock enable is clear
// - Clearing write unlock enable leaves a running cycle untouched
// - Reset during programming sets write error, keeps select bits
// - Launch bits are settable only; hardware clears them at completion
// - Fetch launch cannot be set while memory select is one
// - Data memory read completes in one cycle, then fetch launch clears
// - Completion sets done flag; software clears it
// - Table read uses all 22 pointer bits to pick the byte
// - Block write uses pointer bits 21:3, ignoring low three bits
// - Table operation holds, post-increments, post-decrements or pre-increments

module spfc_top
    import spfc_pkg::*;
#(
    parameter int PROG_CYCLES = `SPFC_PROG_CYCLES,
    parameter int PTR_W       = `SPFC_PTR_W
) (
    input  wire logic                clock_i,
    input  wire logic                reset_i,
    // Table operations from the core
    input  wire spfc_tbl_req_s       tbl_req_i,
    // Register writes from the core
    input  wire logic                ctrl_wr_i,
    input  wire logic                latch_wr_i,
    input  wire logic                ptr_wr_i,
    input  wire logic [7:0]          wdata_i,
    input  wire logic [PTR_W-1:0]    ptr_wdata_i,
    input  wire logic                done_flag_clr_i,
    input  wire logic                bulk_erase_req_i,
    // Instruction fetch path
    input  wire logic [15:0]         fetch_word_i,
    input  wire logic                fetch_word_valid_i,
    output logic      [15:0]         exec_word_o,
    output logic                     fetch_halt_o,
    // Array side
    input  wire logic [7:0]          array_rdata_i,
    input  wire logic [7:0]          nvm_data_rdata_i,
    output spfc_array_cmd_s          array_cmd_o,
    output logic      [63:0]         hold_block_o,
    output logic                     data_read_o,
    output logic      [PTR_W-1:0]    rd_addr_o,
    output logic                     rd_cfg_o,
    output logic                     rd_prog_o,
    // Register read back
    output logic      [7:0]          nvm_control_register_o,
    output logic      [7:0]          table_data_latch_o,
    output logic      [PTR_W-1:0]    table_pointer_o,
    output logic      [7:0]          unlock_port_o,
    output logic      [7:0]          nvm_data_register_o,
    output logic                     nvm_done_irq_flag_o,
    output logic                     bulk_erase_refused_o
);

    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    spfc_state_e      state;
    spfc_state_e      next_state;
    logic [CNT_W-1:0] timer;
    logic [CNT_W-1:0] next_timer;
    logic             memory_select_bit;
    logic             configuration_select_bit;
    logic             row_erase_bit;
    logic             write_error_flag;
    logic             write_unlock_enable_bit;
    logic             cycle_launch_bit;
    logic             fetch_launch_bit;
    logic [7:0]       table_data_latch;
    logic [PTR_W-1:0] table_pointer;
    logic [7:0]       nvm_data_register;
    logic             done_flag;
    logic             prog_busy;
    logic             busy_seen;
    logic             refused;
    logic [PTR_W-1:0] cmd_addr;
    logic             cmd_prog;
    logic             cmd_erase;

    // Pointer arithmetic on the low 21 bits only
    localparam int STEP_W = `SPFC_PTR_STEP_W;
    wire [STEP_W-1:0] ptr_low  = table_pointer[STEP_W-1:0];
    wire [STEP_W-1:0] ptr_inc  = ptr_low + STEP_W'(1);
    wire [STEP_W-1:0] ptr_dec  = ptr_low - STEP_W'(1);
    wire [PTR_W-1:0]  ptr_next_inc = {table_pointer[PTR_W-1:STEP_W], ptr_inc};
    wire [PTR_W-1:0]  ptr_next_dec = {table_pointer[PTR_W-1:STEP_W], ptr_dec};

    // Table operations are dropped while the array is busy
    wire tbl_rd = tbl_req_i.rd && !prog_busy;
    wire tbl_wr = tbl_req_i.wr && !prog_busy;
    wire tbl_any = tbl_rd || tbl_wr;
    wire pre_inc = (tbl_req_i.mode == SPFC_PTR_PREINC);

    // Effective byte address for this operation
    wire [PTR_W-1:0] op_addr = pre_inc ? ptr_next_inc
                                       : table_pointer;

    // Pointer update after the operation
    wire [PTR_W-1:0] next_ptr =
        (tbl_req_i.mode == SPFC_PTR_POSTINC) ? ptr_next_inc :
        (tbl_req_i.mode == SPFC_PTR_POSTDEC) ? ptr_next_dec :
        (tbl_req_i.mode == SPFC_PTR_PREINC)  ? ptr_next_inc :
                                               table_pointer;

    // Table read addressing, all pointer bits
    assign rd_addr_o = op_addr;
    assign rd_cfg_o  = configuration_select_bit;
    assign rd_prog_o = tbl_rd && !configuration_select_bit
                       && memory_select_bit;

    // Control register decode
    wire ctrl_set_launch = ctrl_wr_i && wdata_i[`SPFC_BIT_CYC_LAUNCH];
    wire launch_ok = ctrl_set_launch && write_unlock_enable_bit
                     && (state == SPFC_IDLE);
    wire ctrl_set_fetch = ctrl_wr_i && wdata_i[`SPFC_BIT_FETCH]
                          && !wdata_i[`SPFC_BIT_MEM_SEL] && !launch_ok
                          && (state == SPFC_IDLE);
    wire launch_erase = row_erase_bit;

    // Timer end condition
    wire timer_done = (timer == CNT_W'(1));

    // Next state and timer of the sequencer
    always_comb begin
        next_state = state;
        next_timer = timer;
        case (state)
            SPFC_IDLE: begin
                if (launch_ok) begin
                    next_state = launch_erase ? SPFC_ERASE : SPFC_WRITE;
                    next_timer = CNT_W'(PROG_CYCLES);
                end else if (ctrl_set_fetch) begin
                    next_state = SPFC_DREAD;
                end
            end
            SPFC_WRITE, SPFC_ERASE: begin
                if (timer_done) begin
                    next_state = SPFC_IDLE;
                end
                next_timer = timer - CNT_W'(1);
            end
            default: begin
                next_state = SPFC_IDLE;
            end
        endcase
    end

    // Sequencer state update
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state <= SPFC_IDLE;
            timer <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    assign prog_busy    = (state == SPFC_WRITE) || (state == SPFC_ERASE);
    assign fetch_halt_o = prog_busy;
    wire   prog_end     = prog_busy && timer_done;

    // Select bits keep their value through reset, for error tracing
    always_ff @(posedge clock_i) begin
        if (!reset_i && ctrl_wr_i) begin
            memory_select_bit        <= wdata_i[`SPFC_BIT_MEM_SEL];
            configuration_select_bit <= wdata_i[`SPFC_BIT_CFG_SEL];
        end
    end

    // Write unlock enable, writable while a cycle runs
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            write_unlock_enable_bit <= 1'b0;
        end else if (ctrl_wr_i) begin
            write_unlock_enable_bit <= wdata_i[`SPFC_BIT_WR_UNLOCK];
        end
    end

    // Row erase select: frozen while busy, cleared by the erase end
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            row_erase_bit <= 1'b0;
        end else if (prog_end && state == SPFC_ERASE) begin
            row_erase_bit <= 1'b0;
        end else if (ctrl_wr_i && !prog_busy) begin
            row_erase_bit <= wdata_i[`SPFC_BIT_ROW_ERASE];
        end
    end

    // Cycle launch: settable only, cleared by the timer
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cycle_launch_bit <= 1'b0;
        end else if (launch_ok) begin
            cycle_launch_bit <= 1'b1;
        end else if (prog_end) begin
            cycle_launch_bit <= 1'b0;
        end
    end

    // Fetch launch: settable only, cleared after the one-cycle read
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            fetch_launch_bit <= 1'b0;
        end else if (ctrl_set_fetch) begin
            fetch_launch_bit <= 1'b1;
        end else if (state == SPFC_DREAD) begin
            fetch_launch_bit <= 1'b0;
        end
    end

    // Busy state as seen at the last edge before a reset
    always_ff @(posedge clock_i) begin
        if (!reset_i) begin
            busy_seen <= prog_busy;
        end
    end

    // Write error: no reset; set when a reset cuts a running cycle
    always_ff @(posedge clock_i) begin
        if (reset_i && busy_seen) begin
            write_error_flag <= 1'b1;
        end else if (ctrl_wr_i && !wdata_i[`SPFC_BIT_WR_ERR]) begin
            write_error_flag <= 1'b0;
        end
    end

    // Done flag: completion set wins over software clear
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            done_flag <= 1'b0;
        end else if (prog_end) begin
            done_flag <= 1'b1;
        end else if (done_flag_clr_i) begin
            done_flag <= 1'b0;
        end
    end

    // Table latch, pointer and data register
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            table_data_latch  <= 8'h00;
            table_pointer     <= '0;
            nvm_data_register <= 8'h00;
        end else begin
            if (tbl_rd) begin
                table_data_latch <= array_rdata_i;
            end else if (latch_wr_i) begin
                table_data_latch <= wdata_i;
            end
            if (tbl_any) begin
                table_pointer <= next_ptr;
            end else if (ptr_wr_i) begin
                table_pointer <= ptr_wdata_i;
            end
            if (state == SPFC_DREAD) begin
                nvm_data_register <= nvm_data_rdata_i;
            end
        end
    end

    // Holding registers fed from the latch
    spfc_hold_regs #(
        .DEPTH (`SPFC_HOLD_DEPTH),
        .SEL_W (`SPFC_HOLD_SEL_W)
    ) spfc_hold_regs_i (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .wr_i    (tbl_wr),
        .sel_i   (op_addr[`SPFC_HOLD_SEL_W-1:0]),
        .data_i  (table_data_latch),
        .block_o (hold_block_o)
    );

    // Array command: block or row aligned address
    assign cmd_prog  = (state == SPFC_WRITE);
    assign cmd_erase = (state == SPFC_ERASE);
    assign cmd_addr  = cmd_erase
        ? {table_pointer[PTR_W-1:`SPFC_ROW_LSB], `SPFC_ROW_LSB'(0)}
        : {table_pointer[PTR_W-1:`SPFC_BLOCK_LSB],
           `SPFC_BLOCK_LSB'(0)};
    assign array_cmd_o = '{prog: cmd_prog, erase: cmd_erase,
                           cfg: configuration_select_bit,
                           addr: cmd_addr};
    assign data_read_o = (state == SPFC_DREAD);

    // Bulk erase from on-chip code never starts
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            refused <= 1'b0;
        end else begin
            refused <= bulk_erase_req_i;
        end
    end
    assign bulk_erase_refused_o = refused;

    // Invalid instruction words are replaced by no-operation
    assign exec_word_o = fetch_word_valid_i ? fetch_word_i
                                            : `SPFC_NOP_WORD;

    // Register read back
    assign nvm_control_register_o = {memory_select_bit,
                                     configuration_select_bit, 1'b0,
                                     row_erase_bit, write_error_flag,
                                     write_unlock_enable_bit,
                                     cycle_launch_bit, fetch_launch_bit};
    assign table_data_latch_o  = table_data_latch;
    assign table_pointer_o     = table_pointer;
    assign unlock_port_o       = `SPFC_UNLOCK_READ;
    assign nvm_data_register_o = nvm_data_register;
    assign nvm_done_irq_flag_o = done_flag;

endmodule

`default_nettype wire

// [tb/spfc_array_model.sv]
/*
 * Behavioural flash array and data memory answering the block.
 * Assumes combinational reads keyed by the block's address outputs.
 */
`timescale 1ns/1ps
`default_nettype none

module spfc_array_model #(
    parameter logic [7:0] NVM_BYTE = 8'h5a
) (
    input  wire logic [21:0] rd_addr_i,
    input  wire logic        data_read_i,
    output logic      [7:0]  array_rdata_o,
    output logic      [7:0]  nvm_data_rdata_o
);
    // One byte per access, pattern keyed by address bits 7:0 and 21:16
    assign array_rdata_o = rd_addr_i[7:0] ^ {2'h0, rd_addr_i[21:16]};
    // Data byte only while read strobed, inverse otherwise
    assign nvm_data_rdata_o = data_read_i ? NVM_BYTE : ~NVM_BYTE;
endmodule

`default_nettype wire

// [tb/spfc_top_asserts.sv]
/*
 * Port-level checker for the flash control block.
 * Assumes one clock and an asynchronous active high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module spfc_top_asserts
    import spfc_pkg::*;
#(
    parameter int PROG_CYCLES = 8
) (
    input wire logic            clock_i,
    input wire logic            reset_i,
    input wire logic            ctrl_wr_i,
    input wire logic [7:0]      wdata_i,
    input wire logic            bulk_erase_req_i,
    input wire logic [15:0]     fetch_word_i,
    input wire logic            fetch_word_valid_i,
    input wire logic [15:0]     exec_word_o,
    input wire logic            fetch_halt_o,
    input wire spfc_array_cmd_s array_cmd_o,
    input wire logic            data_read_o,
    input wire logic            rd_cfg_o,
    input wire logic            rd_prog_o,
    input wire logic [7:0]      nvm_control_register_o,
    input wire logic [7:0]      unlock_port_o,
    input wire logic            nvm_done_irq_flag_o,
    input wire logic            bulk_erase_refused_o
);
    logic [15:0] busy_cnt;
    wire logic   launch   = nvm_control_register_o[1];
    wire logic   fetch    = nvm_control_register_o[0];
    wire logic   launch_ok = ctrl_wr_i && wdata_i[1] && nvm_control_register_o[2];
    wire logic   fetch_ok = ctrl_wr_i && wdata_i[0] && !wdata_i[7];
    wire logic   erasing  = array_cmd_o.erase;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    // Cycles spent halted in the current program cycle
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) busy_cnt <= '0;
        else busy_cnt <= fetch_halt_o ? busy_cnt + 16'h1 : '0;
    end

    property p_launch_write_unlock_enable_bit; $rose(launch) |-> $past(launch_ok); endproperty
    a_launch_write_unlock_enable_bit: assert property (p_launch_write_unlock_enable_bit)
        else $error("launch set without unlock");
    property p_fetch_sel; $rose(fetch) |-> $past(fetch_ok); endproperty
    a_fetch_sel: assert property (p_fetch_sel)
        else $error("fetch set with memory select");
    property p_read_one;
        data_read_o |-> fetch ##1 (!fetch && !data_read_o);
    endproperty
    a_read_one: assert property (p_read_one)
        else $error("data read not one cycle");
    property p_halt; $rose(launch) |-> fetch_halt_o && (array_cmd_o.prog || erasing); endproperty
    a_halt: assert property (p_halt)
        else $error("no halt on launch");
    property p_timer; $fell(fetch_halt_o) |-> busy_cnt == 16'(PROG_CYCLES); endproperty
    a_timer: assert property (p_timer)
        else $error("program cycle length wrong");
    property p_done; $fell(launch) |-> nvm_done_irq_flag_o; endproperty
    a_done: assert property (p_done)
        else $error("done flag missing");
    property p_launch_hw; $fell(launch) |-> $past(fetch_halt_o) && !fetch_halt_o; endproperty
    a_launch_hw: assert property (p_launch_hw)
        else $error("launch cleared early");
    property p_row_clr; $fell(erasing) |-> !nvm_control_register_o[4]; endproperty
    a_row_clr: assert property (p_row_clr)
        else $error("row erase bit kept");
    property p_bulk; bulk_erase_req_i |=> bulk_erase_refused_o && !$rose(erasing); endproperty
    a_bulk: assert property (p_bulk)
        else $error("bulk erase not refused");
    property p_nop; exec_word_o == (fetch_word_valid_i ? fetch_word_i : 16'h0000); endproperty
    a_nop: assert property (p_nop)
        else $error("invalid word not nop");
    property p_unlock; unlock_port_o == 8'h00; endproperty
    a_unlock: assert property (p_unlock)
        else $error("unlock port not zero");
    property p_cfg; nvm_control_register_o[6] |-> rd_cfg_o && !rd_prog_o; endproperty
    a_cfg: assert property (p_cfg)
        else $error("config space not selected");

    c_launch: cover property ($rose(launch));
    c_read: cover property (data_read_o);
    c_bulk: cover property (bulk_erase_refused_o);
endmodule

bind spfc_top spfc_top_asserts #(.PROG_CYCLES(PROG_CYCLES)) spfc_chk_i (
    .clock_i(clock_i), .reset_i(reset_i), .ctrl_wr_i(ctrl_wr_i),
    .wdata_i(wdata_i), .bulk_erase_req_i(bulk_erase_req_i),
    .fetch_word_i(fetch_word_i), .fetch_word_valid_i(fetch_word_valid_i),
    .exec_word_o(exec_word_o), .fetch_halt_o(fetch_halt_o),
    .array_cmd_o(array_cmd_o), .data_read_o(data_read_o),
    .rd_cfg_o(rd_cfg_o), .rd_prog_o(rd_prog_o),
    .nvm_control_register_o(nvm_control_register_o),
    .unlock_port_o(unlock_port_o),
    .nvm_done_irq_flag_o(nvm_done_irq_flag_o),
    .bulk_erase_refused_o(bulk_erase_refused_o));

`default_nettype wire

// [tb/spfc_top_tb.sv]
/*
 * Self-checking bench for the flash control block.
 * Assumes the array model answers reads combinationally.
 */
`timescale 1ns/1ps
`default_nettype none

module spfc_top_tb
    import spfc_pkg::*;
;
    logic clock, reset, ctrl_wr, latch_wr, ptr_wr, done_clr, bulk, fvalid;
    logic halt, dread, rd_cfg, rd_prog, done, refused;
    logic [7:0] wdata, arr_rd, nvm_rd, ctrl, latch, nvm_dat;
    logic [21:0] ptr_wdata, rd_addr, ptr, s, a, n;
    logic [15:0] fword, exec_word;
    logic [63:0] hold, exp_hold;
    spfc_tbl_req_s tbl_req;
    spfc_array_cmd_s cmd;
    int failures = 0;
    int n_tests = 0;

    spfc_top #(.PROG_CYCLES(8)) spfc_top_i (
        .clock_i(clock), .reset_i(reset), .tbl_req_i(tbl_req),
        .ctrl_wr_i(ctrl_wr), .latch_wr_i(latch_wr), .ptr_wr_i(ptr_wr),
        .wdata_i(wdata), .ptr_wdata_i(ptr_wdata), .done_flag_clr_i(done_clr),
        .bulk_erase_req_i(bulk), .fetch_word_i(fword),
        .fetch_word_valid_i(fvalid), .exec_word_o(exec_word),
        .fetch_halt_o(halt), .array_rdata_i(arr_rd),
        .nvm_data_rdata_i(nvm_rd), .array_cmd_o(cmd), .hold_block_o(hold),
        .data_read_o(dread), .rd_addr_o(rd_addr), .rd_cfg_o(rd_cfg),
        .rd_prog_o(rd_prog), .nvm_control_register_o(ctrl),
        .table_data_latch_o(latch), .table_pointer_o(ptr),
        .unlock_port_o(), .nvm_data_register_o(nvm_dat),
        .nvm_done_irq_flag_o(done), .bulk_erase_refused_o(refused));

    spfc_array_model spfc_array_model_i (.rd_addr_i(rd_addr),
        .data_read_i(dread), .array_rdata_o(arr_rd),
        .nvm_data_rdata_o(nvm_rd));

    // Verdict and end of run
    task automatic final_report;
        if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    task automatic wr_ctrl(input logic [7:0] v);
        cyc(1); wdata = v; ctrl_wr = 1; cyc(1); ctrl_wr = 0;
    endtask

    task automatic wr_latch(input logic [7:0] v);
        cyc(1); wdata = v; latch_wr = 1; cyc(1); latch_wr = 0;
    endtask

    task automatic wr_ptr(input logic [21:0] v);
        cyc(1); ptr_wdata = v; ptr_wr = 1; cyc(1); ptr_wr = 0;
    endtask

    task automatic tbl(input logic r, input logic w, input spfc_ptr_mode_e m);
        tbl_req = '{rd: r, wr: w, mode: m}; cyc(1); tbl_req = '0;
    endtask

    task automatic wait_idle;
        for (int i = 0; i < 40 && halt === 1'b1; i++) cyc(1);
        chk(halt, 0);
    endtask

    // Core clock
    initial begin
        clock = 0;
        forever #20 clock = ~clock;
    end

    // Hang guard
    initial begin
        #200000;
        failures++;
        final_report;
    end

    // Main sequence
    initial begin
        {reset, ctrl_wr, latch_wr, ptr_wr, done_clr, bulk, fvalid} = 7'h40;
        {wdata, ptr_wdata, fword, tbl_req} = '0;
        cyc(10);
        reset = 0;
        chk(hold, {8{8'hff}});
        wr_ctrl(8'h02); chk(ctrl, 8'h00);
        wr_ctrl(8'hc0); chk(rd_cfg, 1);
        wr_ctrl(8'h81); chk(ctrl, 8'h80);
        wr_ctrl(8'h01); chk({dread, ctrl}, 9'h101);
        cyc(1); chk({ctrl, nvm_dat}, 16'h005a);
        // Every pointer variant at both ends of the low 21 bits
        for (int j = 0; j < 8; j++) begin
            s = j[2] ? 22'h200000 : 22'h3fffff;
            n = {s[21], s[20:0] + 21'h1};
            if (j[1:0] == 2) n = {s[21], s[20:0] - 21'h1};
            if (j[1:0] == 0) n = s;
            a = (j[1:0] == 3) ? n : s;
            wr_ptr(s);
            tbl(1, 0, spfc_ptr_mode_e'(j[1:0]));
            chk(latch, a[7:0] ^ {2'h0, a[21:16]});
            chk(ptr, n);
        end
        // Unaligned eight-byte fill of the holding registers
        exp_hold = {8{8'hff}};
        wr_ptr(22'h000105);
        for (int i = 0; i < 8; i++) begin
            wr_latch(8'h10 + 8'(i));
            tbl(0, 1, SPFC_PTR_POSTINC);
            exp_hold[8 * ((5 + i) % 8) +: 8] = 8'h10 + 8'(i);
        end
        chk(hold, exp_hold);
        chk(ptr, 22'h00010d);
        // Block write, unlock dropped mid-cycle
        wr_ctrl(8'h84); wr_ctrl(8'h86); chk({halt, cmd.prog}, 2'b11);
        chk(cmd.addr, 22'h000108);
        wr_ctrl(8'h80); chk(ctrl[1], 1);
        wait_idle;
        chk({ctrl, done}, 9'h101);
        done_clr = 1; cyc(1); done_clr = 0; chk(done, 0);
        // Row erase
        wr_ctrl(8'h94); wr_ctrl(8'h96); chk(cmd.erase, 1);
        chk(cmd.addr, 22'h000100);
        wait_idle;
        chk(ctrl, 8'h84);
        bulk = 1; cyc(1); bulk = 0; chk({refused, cmd.erase}, 2'b10);
        fword = 16'h1234; #1 chk(exec_word, 16'h0000);
        fvalid = 1; #1 chk(exec_word, 16'h1234);
        // Reset in mid-cycle leaves the error flag
        wr_ctrl(8'h84); wr_ctrl(8'h86); cyc(2);
        reset = 1; cyc(1); reset = 0;
        chk({ctrl[7:6], ctrl[3]}, 3'b101);
        wr_ptr(22'h000104);
        wr_ctrl(8'h00); chk(ctrl, 8'h00);
        final_report;
    end
endmodule

`default_nettype wire
